//--- prt_regs.svh
`ifndef PRT_REGS_SVH
`define PRT_REGS_SVH

// ----------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------
`define PRT_IDX_CTRL 10'h100
`define PRT_IDX_IOCTL 10'h101
`define PRT_IDX_MODE 10'h102
`define PRT_IDX_PRE 10'h103
`define PRT_IDX_MAIN 10'h104

// ----------------------------------------------------------------------
// Control register bit positions.
// ----------------------------------------------------------------------
`define PRT_CTRL_START 0
`define PRT_CTRL_STATUS 1
`define PRT_CTRL_STOP 2
`define PRT_CTRL_EDGE 4
`define PRT_CTRL_UNDF 5

// ----------------------------------------------------------------------
// Reset values and filter settings.
// ----------------------------------------------------------------------
`define PRT_BYTE_RST 8'h00
`define PRT_CNT_RST 8'hff
`define PRT_FILT_OFF 2'b00
`define PRT_FILT_F1 2'b01
`define PRT_FILT_F8 2'b10
`define PRT_FILT_F32 2'b11

`endif

//--- prt_pkg.sv
package prt_pkg;

    // ------------------------------------------------------------------
    // Operating modes and count sources.
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PRT_MODE_TIMER = 3'b000,
        PRT_MODE_PULSE = 3'b001,
        PRT_MODE_EVENT = 3'b010,
        PRT_MODE_PWIDTH = 3'b011,
        PRT_MODE_PPERIOD = 3'b100
    } prt_mode_t;

    typedef enum logic [2:0] {
        PRT_SRC_F1 = 3'b000,
        PRT_SRC_F8 = 3'b001,
        PRT_SRC_OCO = 3'b010,
        PRT_SRC_F2 = 3'b011,
        PRT_SRC_SUB32K = 3'b100
    } prt_src_t;

    // ------------------------------------------------------------------
    // Register layouts.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] reserved;
        logic input_filter_select_high;
        logic input_filter_select_low;
        logic pin_select;
        logic secondary_output_enable;
        logic output_stop_control;
        logic polarity_select;
    } prt_io_ctl_t;

    typedef struct packed {
        logic reserved_hi;
        prt_src_t src;
        logic reserved_lo;
        prt_mode_t mode;
    } prt_mode_reg_t;

    typedef struct packed {
        logic out;
        logic oe;
    } prt_pin_t;

endpackage

//--- prt_timer.sv
// The APB register port was decided locally.
`timescale 1ns/100ps
`include "prt_regs.svh"

module prt_timer
    import prt_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic on_chip_oscillator_clock,
    input wire logic subclock_32k,
    input wire logic pin_a_in,
    output prt_pin_t pin_a,
    input wire logic pin_b_in,
    output prt_pin_t pin_b,
    output prt_pin_t secondary_output_pin,
    output logic timer_irq
);

    // ------------------------------------------------------------------
    // Register bus decode.
    // ------------------------------------------------------------------
    logic [9:0] idx;
    logic hit, wr, wr_ctrl, wr_io, wr_mode, wr_pre, wr_main, wr_stop, apb_setup;

    assign idx = paddr[11:2];
    assign hit = (paddr[1:0] == 2'b00) && (idx >= `PRT_IDX_CTRL) && (idx <= `PRT_IDX_MAIN);
    assign apb_setup = psel & ~penable;
    assign wr = psel & penable & pwrite & hit;
    assign wr_ctrl = wr && (idx == `PRT_IDX_CTRL);
    assign wr_io = wr && (idx == `PRT_IDX_IOCTL);
    assign wr_mode = wr && (idx == `PRT_IDX_MODE);
    assign wr_pre = wr && (idx == `PRT_IDX_PRE);
    assign wr_main = wr && (idx == `PRT_IDX_MAIN);
    assign wr_stop = wr_ctrl & pwdata[`PRT_CTRL_STOP];
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // ------------------------------------------------------------------
    // Configuration registers.
    // ------------------------------------------------------------------
    prt_io_ctl_t io_q;
    prt_mode_reg_t mode_q;
    logic is_pulse, is_event, is_pw;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_q <= prt_io_ctl_t'(`PRT_BYTE_RST);
        end else if (wr_io) begin
            io_q <= prt_io_ctl_t'({2'b00, pwdata[5:0]});
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= prt_mode_reg_t'(`PRT_BYTE_RST);
        end else if (wr_mode) begin
            mode_q <= prt_mode_reg_t'({1'b0, pwdata[6:4], 1'b0, pwdata[2:0]});
        end
    end

    assign is_pulse = (mode_q.mode == PRT_MODE_PULSE);
    assign is_event = (mode_q.mode == PRT_MODE_EVENT);
    assign is_pw = (mode_q.mode == PRT_MODE_PWIDTH);

    // ------------------------------------------------------------------
    // Dividers and synchronisers.
    // ------------------------------------------------------------------
    logic [4:0] div_q;
    logic f2_en, f8_en, f32_en;
    logic [3:0] meta_q, sync_q, sync_d1_q;
    logic oco_rise, sub_rise, pin_raw;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 5'h00;
        end else begin
            div_q <= div_q + 5'h01;
        end
    end

    assign f2_en = div_q[0];
    assign f8_en = &div_q[2:0];
    assign f32_en = &div_q;

    // The oscillator and subclock are far slower than pclk, so their edges are
    // recovered as enables instead of opening new clock domains.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 4'h0;
            sync_q <= 4'h0;
            sync_d1_q <= 4'h0;
        end else begin
            meta_q <= {subclock_32k, on_chip_oscillator_clock, pin_b_in, pin_a_in};
            sync_q <= meta_q;
            sync_d1_q <= sync_q;
        end
    end

    assign oco_rise = sync_q[2] & ~sync_d1_q[2];
    assign sub_rise = sync_q[3] & ~sync_d1_q[3];
    assign pin_raw = io_q.pin_select ? sync_q[1] : sync_q[0];

    // ------------------------------------------------------------------
    // Input digital filter.
    // ------------------------------------------------------------------
    logic [1:0] fsel;
    logic filt_smp, filt_q, filt_d1_q, in_rise, in_fall;
    logic [2:0] fsh_q;

    assign fsel = {io_q.input_filter_select_high, io_q.input_filter_select_low};

    always_comb begin
        unique case (fsel)
            `PRT_FILT_F1: filt_smp = 1'b1;
            `PRT_FILT_F8: filt_smp = f8_en;
            `PRT_FILT_F32: filt_smp = f32_en;
            `PRT_FILT_OFF: filt_smp = 1'b0;
        endcase
    end

    // Three equal samples are needed to move the filtered level, so a glitch
    // no longer than two sampling periods never reaches the counter.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fsh_q <= 3'h0;
            filt_q <= 1'b0;
            filt_d1_q <= 1'b0;
        end else begin
            if (filt_smp) begin
                fsh_q <= {fsh_q[1:0], pin_raw};
            end
            if (fsel == `PRT_FILT_OFF) begin
                filt_q <= pin_raw;
            end else if (&fsh_q) begin
                filt_q <= 1'b1;
            end else if (~|fsh_q) begin
                filt_q <= 1'b0;
            end
            filt_d1_q <= filt_q;
        end
    end

    assign in_rise = filt_q & ~filt_d1_q;
    assign in_fall = ~filt_q & filt_d1_q;

    // ------------------------------------------------------------------
    // Count source selection and start control.
    // ------------------------------------------------------------------
    logic int_tick, src_tick, level_ok, cnt_tick, pw_end;
    logic start_q, running_q;

    always_comb begin
        unique case (mode_q.src)
            PRT_SRC_F1: int_tick = 1'b1;
            PRT_SRC_F2: int_tick = f2_en;
            PRT_SRC_F8: int_tick = f8_en;
            PRT_SRC_OCO: int_tick = oco_rise;
            PRT_SRC_SUB32K: int_tick = sub_rise;
            default: int_tick = 1'b0;
        endcase
    end

    // Timer and pulse output modes never look at the filter, and polarity only sets the
    // output start level at a mode write, so a nonzero filter setting there is harmless but pointless.
    assign src_tick = is_event ? (io_q.polarity_select ? in_fall : in_rise) : int_tick;
    assign level_ok = ~is_pw | (filt_q == io_q.polarity_select);
    assign cnt_tick = running_q & src_tick & level_ok;
    assign pw_end = is_pw & running_q & (io_q.polarity_select ? in_fall : in_rise);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_q <= 1'b0;
        end else if (wr_ctrl) begin
            start_q <= pwdata[`PRT_CTRL_START] & ~pwdata[`PRT_CTRL_STOP];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running_q <= 1'b0;
        end else if (wr_ctrl && (pwdata[`PRT_CTRL_STOP] || !pwdata[`PRT_CTRL_START])) begin
            running_q <= 1'b0;
        end else if (start_q && src_tick) begin
            running_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Prescaler and main timer stages.
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] pre_rel_q, pre_cnt_q, main_rel_q, main_cnt_q;
    logic pre_pend_q, main_pend_q, pre_uf, main_uf;

    assign pre_uf = cnt_tick & ~pre_pend_q & (pre_cnt_q == '0);
    assign main_uf = pre_uf & ~main_pend_q & (main_cnt_q == '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_rel_q <= `PRT_CNT_RST;
            pre_cnt_q <= `PRT_CNT_RST;
            pre_pend_q <= 1'b0;
        end else if (wr_stop) begin
            pre_rel_q <= `PRT_CNT_RST;
            pre_cnt_q <= `PRT_CNT_RST;
            pre_pend_q <= 1'b0;
        end else if (wr_pre) begin
            pre_rel_q <= pwdata[CNT_W-1:0];
            if (!running_q) begin
                pre_cnt_q <= pwdata[CNT_W-1:0];
            end
            pre_pend_q <= running_q;
        end else if (running_q && src_tick && pre_pend_q) begin
            pre_cnt_q <= pre_rel_q;
            pre_pend_q <= 1'b0;
        end else if (cnt_tick) begin
            pre_cnt_q <= pre_uf ? pre_rel_q : pre_cnt_q - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_rel_q <= `PRT_CNT_RST;
            main_cnt_q <= `PRT_CNT_RST;
            main_pend_q <= 1'b0;
        end else if (wr_stop) begin
            main_rel_q <= `PRT_CNT_RST;
            main_cnt_q <= `PRT_CNT_RST;
            main_pend_q <= 1'b0;
        end else if (wr_main) begin
            main_rel_q <= pwdata[CNT_W-1:0];
            if (!running_q) begin
                main_cnt_q <= pwdata[CNT_W-1:0];
            end
            main_pend_q <= running_q;
        end else if (pre_uf && main_pend_q) begin
            main_cnt_q <= main_rel_q;
            main_pend_q <= 1'b0;
        end else if (pre_uf) begin
            main_cnt_q <= main_uf ? main_rel_q : main_cnt_q - 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Flags and interrupt.
    // ------------------------------------------------------------------
    logic edge_q, undf_q;

    // A hardware event in the same cycle as a clearing write wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_q <= 1'b0;
            undf_q <= 1'b0;
        end else begin
            if (pw_end) begin
                edge_q <= 1'b1;
            end else if (wr_ctrl && !pwdata[`PRT_CTRL_EDGE]) begin
                edge_q <= 1'b0;
            end
            if (main_uf) begin
                undf_q <= 1'b1;
            end else if (wr_ctrl && !pwdata[`PRT_CTRL_UNDF]) begin
                undf_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= main_uf | pw_end;
        end
    end

    // ------------------------------------------------------------------
    // Pulse outputs.
    // ------------------------------------------------------------------
    logic out_q, sec_q, prim_drv;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= 1'b1;
            sec_q <= 1'b0;
        end else if (wr_mode) begin
            out_q <= ~io_q.polarity_select;
            sec_q <= io_q.polarity_select;
        end else if (main_uf) begin
            if (is_pulse) begin
                out_q <= ~out_q;
            end
            if (is_event) begin
                sec_q <= ~sec_q;
            end
        end
    end

    assign prim_drv = is_pulse & ~io_q.output_stop_control;
    assign pin_a.out = out_q;
    assign pin_a.oe = prim_drv & ~io_q.pin_select;
    assign pin_b.out = out_q;
    assign pin_b.oe = prim_drv & io_q.pin_select;
    assign secondary_output_pin.out = is_pulse ? ~out_q : sec_q;
    assign secondary_output_pin.oe = io_q.secondary_output_enable & (is_pulse | is_event);

    // ------------------------------------------------------------------
    // Read data, captured in the setup phase.
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup) begin
            unique case (idx)
                `PRT_IDX_CTRL: prdata <= {26'h0, undf_q, edge_q, 2'b00, running_q, start_q};
                `PRT_IDX_IOCTL: prdata <= {24'h0, io_q};
                `PRT_IDX_MODE: prdata <= {24'h0, mode_q};
                `PRT_IDX_PRE: prdata <= {24'h0, pre_cnt_q};
                `PRT_IDX_MAIN: prdata <= {24'h0, main_cnt_q};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence pre_wr_run_s;
        wr_pre && running_q;
    endsequence

    sequence quiet_s;
        !wr_pre && !wr_main && !wr_stop;
    endsequence

    pre_reload_a: assert property ((pre_uf && !wr) |=> pre_cnt_q == $past(pre_rel_q))
        else $error("prescaler did not reload on underflow");
    pre_dec_a: assert property ((cnt_tick && !pre_pend_q && pre_cnt_q != '0 && !wr)
        |=> pre_cnt_q == $past(pre_cnt_q) - 1'b1)
        else $error("prescaler did not decrement");
    main_gate_a: assert property ((!pre_uf and quiet_s) |=> $stable(main_cnt_q))
        else $error("main counter moved without prescaler underflow");
    wr_hold_a: assert property (pre_wr_run_s |=> $stable(pre_cnt_q) && pre_pend_q)
        else $error("counter changed at a write while counting");
    irq_uf_a: assert property (main_uf |=> timer_irq && undf_q)
        else $error("underflow without interrupt");
    pulse_tog_a: assert property ((is_pulse && main_uf && !wr_mode) |=> out_q != $past(out_q))
        else $error("pulse output did not toggle");
    mode_lvl_a: assert property (wr_mode |=> out_q == !$past(io_q.polarity_select))
        else $error("mode write did not restore start level");
    stop_halt_a: assert property (wr_stop |=> !running_q && !start_q ##1 !running_q)
        else $error("forcible stop did not halt");
    start_src_a: assert property ($rose(running_q) |-> $past(start_q) && $past(src_tick))
        else $error("status rose without a source edge");
    flag_keep_a: assert property ((wr_ctrl && pwdata[`PRT_CTRL_UNDF] && !main_uf)
        |=> undf_q == $past(undf_q))
        else $error("writing one changed the underflow flag");

endmodule // prt_timer

//--- prt_pin_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// External pulse source and load on the two alternative timer pins.
// ----------------------------------------------------------------------
module prt_pin_model
    import prt_pkg::*;
(
    input wire logic pclk,
    input wire prt_pin_t pin_a,
    input wire prt_pin_t pin_b,
    output logic pin_a_in,
    output logic pin_b_in
);
    logic drv_a = 1'b0;
    logic drv_b = 1'b0;

    // The timer wins the wire while it drives, so a pin in output use reads back its own level.
    assign pin_a_in = pin_a.oe ? pin_a.out : drv_a;
    assign pin_b_in = pin_b.oe ? pin_b.out : drv_b;

    task automatic level(input logic sel, input logic v, input int cyc);
        @(posedge pclk);
        if (sel) drv_b <= v;
        else drv_a <= v;
        repeat (cyc - 1) @(posedge pclk);
    endtask

    task automatic pulses(input logic sel, input int hi, input int lo, input int cnt);
        for (int i = 0; i < cnt; i++) begin
            level(sel, 1'b1, hi);
            level(sel, 1'b0, lo);
        end
    endtask
endmodule // prt_pin_model

//--- test_prescaled_reload_timer_modes.sv
`timescale 1ns/100ps
`include "prt_regs.svh"
module test_prescaled_reload_timer_modes
    import prt_pkg::*;
;
    localparam logic [11:0] A_CTRL = {`PRT_IDX_CTRL, 2'b00};
    localparam logic [11:0] A_IOC = {`PRT_IDX_IOCTL, 2'b00};
    localparam logic [11:0] A_MODE = {`PRT_IDX_MODE, 2'b00};
    localparam logic [11:0] A_PRE = {`PRT_IDX_PRE, 2'b00};
    localparam logic [11:0] A_MAIN = {`PRT_IDX_MAIN, 2'b00};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic oco = 1'b0;
    logic sub = 1'b0;
    logic pin_a_in;
    logic pin_b_in;
    prt_pin_t pin_a;
    prt_pin_t pin_b;
    prt_pin_t sec;
    logic timer_irq;
    logic [7:0] div_q = 8'h00;
    logic [31:0] rnd = 32'h0c93d5c9;
    logic [31:0] r;
    logic e;
    logic [1:0] n;
    logic [1:0] m;
    int n_mismatch = 0;
    int n_checks = 0;
    int n_irq = 0;
    int cyc = 0;
    int t_irq = 0;
    int c, k, t;
    int dv[5] = '{1, 2, 8, 8, 32};
    logic [2:0] sr[5] = '{3'h0, 3'h3, 3'h1, 3'h2, 3'h4};

    prt_timer #(.CNT_W(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .on_chip_oscillator_clock(oco), .subclock_32k(sub), .pin_a_in(pin_a_in),
        .pin_a(pin_a), .pin_b_in(pin_b_in), .pin_b(pin_b), .secondary_output_pin(sec),
        .timer_irq(timer_irq));
    prt_pin_model PIN (.pclk(pclk), .pin_a(pin_a), .pin_b(pin_b), .pin_a_in(pin_a_in),
        .pin_b_in(pin_b_in));

    // ------------------------------------------------------------------
    // Clock, slow sources and event counters.
    // ------------------------------------------------------------------
    always #4 pclk = ~pclk;

    always @(posedge pclk) begin
        div_q <= div_q + 8'h01;
        oco <= div_q[2];
        sub <= div_q[4];
        cyc <= cyc + 1;
        if (timer_irq === 1'b1) n_irq <= n_irq + 1;
    end

    // ------------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Holds the whole request until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
        output logic [31:0] rv, output logic ev);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 20) begin
            n_mismatch++;
            end_of_test();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] rv;
        logic ev;
        apb(1'b1, a, d, rv, ev);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rv;
        logic ev;
        apb(1'b0, a, 8'h00, rv, ev);
        chk(rv, exp);
    endtask

    task automatic wait_irq(output int w);
        w = 0;
        do begin
            @(posedge pclk);
            w++;
        end while (timer_irq !== 1'b1 && w < 4000);
        t_irq = cyc;
        if (w >= 4000) begin
            n_mismatch++;
            end_of_test();
        end
    endtask

    task automatic setup(input logic [7:0] pre, input logic [7:0] mv, input logic [7:0] mode);
        wr(A_CTRL, 8'h04);
        wr(A_PRE, pre);
        wr(A_MAIN, mv);
        wr(A_MODE, mode);
        wr(A_CTRL, 8'h01);
    endtask

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdc(A_CTRL, 32'h0);
        rdc(A_IOC, 32'h0);
        rdc(A_PRE, 32'hff);
        apb(1'b0, 12'h500, 8'h00, r, e);
        chk({31'h0, e}, 32'h1);
        wr(A_IOC, 8'h3f);
        rdc(A_IOC, 32'h3f);
        wr(A_PRE, 8'h05);
        wr(A_MAIN, 8'h07);
        rdc(A_PRE, 32'h05);
        rdc(A_MAIN, 32'h07);
        wr(A_IOC, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            rnd = lfsr(rnd);
            n = rnd[1:0];
            m = rnd[3:2];
            setup({6'h0, n}, {6'h0, m}, {1'b0, sr[i], 4'h0});
            // Status may lag the start bit by one source period, so it is read after an underflow.
            wait_irq(c);
            apb(1'b0, A_CTRL, 8'h00, r, e);
            chk({29'h0, r[2:0]}, 32'h3);
            wait_irq(c);
            wait_irq(c);
            chk(32'(c), 32'(dv[i] * (n + 1) * (m + 1)));
        end
        wait_irq(c);
        wr(A_CTRL, 8'h00);
        repeat (3) @(posedge pclk);
        k = n_irq;
        repeat (40) @(posedge pclk);
        chk(32'(n_irq - k), 32'h0);
        wr(A_CTRL, 8'h01);
        wait_irq(c);
        wr(A_CTRL, 8'h04);
        rdc(A_CTRL, 32'h0);
        rdc(A_MAIN, 32'hff);
        $display("test sources done");
        // Slow source leaves room for register traffic between two underflows.
        setup(8'h03, 8'h02, 8'h40);
        wait_irq(c);
        t = t_irq;
        rdc(A_CTRL, 32'h23);
        rdc(A_MAIN, 32'h02);
        wr(A_MAIN, 8'h05);
        rdc(A_MAIN, 32'h02);
        wr(A_CTRL, 8'h21);
        rdc(A_CTRL, 32'h23);
        wr(A_CTRL, 8'h01);
        rdc(A_CTRL, 32'h03);
        wait_irq(c);
        chk(32'(t_irq - t), 32'd896);
        wait_irq(c);
        chk(32'(c), 32'd768);
        $display("test reload done");
        wr(A_IOC, 8'h04);
        wr(A_CTRL, 8'h04);
        wr(A_PRE, 8'h01);
        wr(A_MAIN, 8'h01);
        wr(A_MODE, 8'h01);
        @(negedge pclk);
        chk({30'h0, pin_a}, 32'h3);
        chk({30'h0, sec}, 32'h1);
        wr(A_CTRL, 8'h01);
        wait_irq(c);
        @(negedge pclk);
        chk({31'h0, pin_a.out}, 32'h0);
        chk({31'h0, sec.out}, 32'h1);
        wr(A_CTRL, 8'h04);
        wr(A_IOC, 8'h0d);
        wr(A_MODE, 8'h01);
        @(negedge pclk);
        chk({30'h0, pin_b}, 32'h1);
        chk({31'h0, pin_a.oe}, 32'h0);
        wr(A_IOC, 8'h0f);
        @(negedge pclk);
        chk({31'h0, pin_b.oe}, 32'h0);
        $display("test pulse done");
        wr(A_IOC, 8'h04);
        setup(8'h00, 8'h02, 8'h02);
        k = n_irq;
        for (int i = 0; i < 6 && n_irq == k; i++) PIN.pulses(1'b0, 6, 10, 1);
        k = n_irq;
        PIN.pulses(1'b0, 6, 10, 2);
        chk(32'(n_irq - k), 32'h0);
        PIN.pulses(1'b0, 6, 10, 1);
        chk(32'(n_irq - k), 32'h1);
        chk({30'h0, sec}, 32'h1);
        wr(A_IOC, 8'h35);
        k = n_irq;
        PIN.pulses(1'b0, 6, 10, 3);
        chk(32'(n_irq - k), 32'h0);
        PIN.pulses(1'b0, 160, 160, 3);
        chk(32'(n_irq - k), 32'h1);
        wr(A_CTRL, 8'h04);
        wr(A_MODE, 8'h02);
        @(negedge pclk);
        chk({31'h0, sec.out}, 32'h1);
        $display("test event done");
        wr(A_IOC, 8'h00);
        PIN.level(1'b0, 1'b1, 4);
        setup(8'h00, 8'd200, 8'h03);
        repeat (20) @(posedge pclk);
        rdc(A_MAIN, 32'd200);
        k = n_irq;
        PIN.level(1'b0, 1'b0, 30);
        PIN.level(1'b0, 1'b1, 10);
        chk(32'(n_irq - k), 32'h1);
        apb(1'b0, A_CTRL, 8'h00, r, e);
        chk({31'h0, r[4]}, 32'h1);
        apb(1'b0, A_MAIN, 8'h00, r, e);
        chk({31'h0, r >= 32'd168 && r <= 32'd172}, 32'h1);
        $display("test width done");
        end_of_test();
    end
endmodule // test_prescaled_reload_timer_modes
